// ===== fir_loader_pkg.sv
// Shared constants for the FIR coefficient loader and its host controller
package fir_loader_pkg;
    localparam int NUM_COEFF = 48;
    localparam int MAG_W = 26;
    localparam int COEFF_W = 27;
    localparam int SIGN_BIT = 26;
    localparam int LEN_CODE_W = 4;
    localparam int CHK_W = 16;
    // Device control word 1 and status word layout
    localparam logic [15:0] CTRL1_ADDR = 16'h0001;
    localparam logic [15:0] STATUS_ADDR = 16'h0002;
    localparam int DL_REQ_BIT = 15;
    localparam int LEN_CODE_LSB = 5;
    localparam int VERIFIED_BIT = 7;
    // Default coefficient count and pad-word field positions
    localparam logic [LEN_CODE_W-1:0] LEN_CODE_DEFAULT = 4'h0;
    localparam int WORD1_PAD_LSB = 11;
    localparam int ZERO_FILL_CYCLES = 1;
    // Host command register map
    localparam logic [3:0] H_CTRL = 4'h0;
    localparam logic [3:0] H_STATUS = 4'h1;
    localparam logic [3:0] H_IRQ_STAT = 4'h2;
    localparam logic [3:0] H_IRQ_MASK = 4'h3;
    localparam logic [3:0] H_COEFF = 4'h4;
    localparam logic [3:0] H_CHECK = 4'h5;
    localparam logic [3:0] H_REG_ADDR = 4'h6;
    localparam logic [3:0] H_REG_DATA = 4'h7;

    // Default 48-entry half response, sign-magnitude
    localparam logic [26:0] DEFAULT_COEFF [0:47] = '{
        27'h332bca0, 27'h17fa5a0, 27'h444a196, 27'h4b62067, 27'h4140c31, 27'h06a734e,
        27'h031dddb, 27'h439e6b2, 27'h4392e4a, 27'h01709d9, 27'h0344ef8, 27'h001397f,
        27'h428c5fc, 27'h4101f74, 27'h01a92fb, 27'h016ebf8, 27'h40cc178, 27'h4175250,
        27'h0016dba, 27'h0135efe, 27'h006466d, 27'h40d2f26, 27'h40a242e, 27'h006a139,
        27'h00ab1af, 27'h401150a, 27'h408e917, 27'h402af3e, 27'h005ee3b, 27'h0047c70,
        27'h402cbd2, 27'h4049e05, 27'h0003ea2, 27'h003a2eb, 27'h00158ca, 27'h4022f65,
        27'h401f797, 27'h000ca52, 27'h001dc13, 27'h000402a, 27'h401619c, 27'h400f99b,
        27'h000b0b2, 27'h001c020, 27'h0018fd5, 27'h000cdbd, 27'h0003cc7, 27'h00007ab};
endpackage : fir_loader_pkg

// ===== fir_bus_if.sv
// Parallel word bus between host controller and coefficient loader
`timescale 1ns/1ps
interface fir_bus_if;
    logic wr;
    logic is_addr;
    logic [15:0] wdata;
    logic rd;
    logic [15:0] rdata;
    logic rvalid;
    logic data_word_verified;
    modport dev (input wr, input is_addr, input wdata, input rd,
                 output rdata, output rvalid, output data_word_verified);
    modport host (output wr, output is_addr, output wdata, output rd,
                  input rdata, input rvalid, input data_word_verified);
endinterface : fir_bus_if

// ===== fir_coefficient_loader.sv
// Device end: coefficient download, checksum check and coefficient store
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module fir_coefficient_loader #(
    parameter int NCOEFF = fir_loader_pkg::NUM_COEFF
) (
    input wire logic CLK,
    input wire logic SRST,
    fir_bus_if.dev BUS,
    input wire logic [5:0] COEFF_IDX,
    output logic [26:0] COEFF_VAL,
    output logic BUSY
);
    initial begin
        if (NCOEFF != fir_loader_pkg::NUM_COEFF) begin
            $error("NCOEFF must be 48");
        end
    end

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DATA = 3'b001,
        S_HI = 3'b010,
        S_LO = 3'b011,
        S_CHK = 3'b100,
        S_FILL = 3'b101
    } dstate_t;

    dstate_t state_ff, nxt_state;
    logic [26:0] mem_ff [0:47];
    logic [15:0] addr_ff;
    logic [15:0] hi_ff;
    logic [5:0] idx_ff;
    logic [5:0] count_ff;
    logic [15:0] sum_ff;
    logic verified_ff;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    logic [26:0] coeff_ff;

    wire word_wr = BUS.wr && !BUS.is_addr;
    wire ctrl1_hit = addr_ff == fir_loader_pkg::CTRL1_ADDR;
    wire [3:0] len_code = BUS.wdata[fir_loader_pkg::LEN_CODE_LSB +: 4];
    wire dl_req = word_wr && ctrl1_hit && BUS.wdata[fir_loader_pkg::DL_REQ_BIT]
        && state_ff == S_DATA;
    // Odd codes give 6 per step; code 0 (or an even code) starts no download and keeps the stored set
    wire [5:0] ncoef = len_code[0] ? 6'((len_code[3:1] + 4'h1) * 6) : 6'd0;
    // Byte sum of one padded word pair
    wire [15:0] byte_sum = 16'(hi_ff[15:8]) + 16'(hi_ff[7:0])
        + 16'(BUS.wdata[15:8]) + 16'(BUS.wdata[7:0]);
    wire [26:0] new_coeff = {hi_ff[10:0], BUS.wdata};
    wire last_coeff = idx_ff == count_ff - 6'd1;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: if (BUS.wr && BUS.is_addr) nxt_state = S_DATA;
            S_DATA: begin
                if (word_wr) begin
                    nxt_state = (dl_req && ncoef != 6'd0) ? S_HI : S_IDLE;
                end
            end
            S_HI: if (word_wr) nxt_state = S_LO;
            S_LO: if (word_wr) nxt_state = last_coeff ? S_CHK : S_HI;
            S_CHK: if (word_wr) nxt_state = (count_ff == 6'd48) ? S_IDLE : S_FILL;
            S_FILL: if (idx_ff == 6'd47) nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_ff <= S_IDLE;
            for (int i = 0; i < 48; i++) begin
                mem_ff[i] <= fir_loader_pkg::DEFAULT_COEFF[i];
            end
            addr_ff <= 16'h0000;
            hi_ff <= 16'h0000;
            idx_ff <= 6'd0;
            count_ff <= 6'd0;
            sum_ff <= 16'h0000;
            verified_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (BUS.wr && BUS.is_addr) addr_ff <= BUS.wdata;
            if (dl_req && ncoef != 6'd0) begin
                verified_ff <= 1'b0;
                count_ff <= ncoef;
                idx_ff <= 6'd0;
                sum_ff <= 16'h0000;
            end
            if (state_ff == S_HI && word_wr) hi_ff <= BUS.wdata;
            if (state_ff == S_LO && word_wr) begin
                mem_ff[idx_ff] <= new_coeff;
                sum_ff <= sum_ff + byte_sum;
                if (!last_coeff) idx_ff <= idx_ff + 6'd1;
            end
            if (state_ff == S_CHK && word_wr) begin
                verified_ff <= BUS.wdata == sum_ff;
                idx_ff <= count_ff;
            end
            if (state_ff == S_FILL) begin
                // One location per clock, well inside the host wait
                mem_ff[idx_ff] <= 27'h0000000;
                idx_ff <= idx_ff + 6'd1;
            end
        end
    end

    wire stat_rd = BUS.rd && addr_ff == fir_loader_pkg::STATUS_ADDR;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
            coeff_ff <= 27'h0000000;
        end else begin
            rvalid_ff <= BUS.rd;
            rdata_ff <= stat_rd ? (16'(verified_ff) << fir_loader_pkg::VERIFIED_BIT)
                : 16'h0000;
            coeff_ff <= mem_ff[COEFF_IDX];
        end
    end

    assign BUS.rdata = rdata_ff;
    assign BUS.rvalid = rvalid_ff;
    assign BUS.data_word_verified = verified_ff;
    assign COEFF_VAL = coeff_ff;
    assign BUSY = state_ff == S_FILL;
endmodule : fir_coefficient_loader

// ===== fir_download_host.sv
// Host end: issues register writes, coefficient words and checksum
`timescale 1ns/1ps
module fir_download_host (
    input wire logic CLK,
    input wire logic SRST,
    fir_bus_if.host BUS,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    output logic IRQ
);
    logic wr_ff;
    logic isa_ff;
    logic rd_ff;
    logic [15:0] wd_ff;
    logic [15:0] rdata_ff;
    logic [15:0] status_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic verified_q_ff;

    // Host sends words as given: coefficient order and scaling are software's
    wire w_addr = WR && (ADDR == fir_loader_pkg::H_REG_ADDR);
    wire w_data = WR && (ADDR == fir_loader_pkg::H_REG_DATA || ADDR == fir_loader_pkg::H_COEFF
        || ADDR == fir_loader_pkg::H_CHECK);
    wire ev_read = BUS.rvalid;
    wire ev_ver = BUS.data_word_verified && !verified_q_ff;
    wire [1:0] ev = {ev_ver, ev_read};
    wire [1:0] clr = (WR && ADDR == fir_loader_pkg::H_IRQ_STAT) ? WDATA[1:0] : 2'b00;
    wire [15:0] rsel = (ADDR == fir_loader_pkg::H_STATUS) ? status_ff
        : (ADDR == fir_loader_pkg::H_IRQ_STAT) ? {14'h0000, irq_stat_ff}
        : (ADDR == fir_loader_pkg::H_IRQ_MASK) ? {14'h0000, irq_mask_ff}
        : (ADDR == fir_loader_pkg::H_CTRL) ? {15'h0000, BUS.data_word_verified}
        : 16'h0000;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wr_ff <= 1'b0;
            isa_ff <= 1'b0;
            rd_ff <= 1'b0;
            wd_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
            status_ff <= 16'h0000;
            irq_stat_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
            verified_q_ff <= 1'b0;
        end else begin
            wr_ff <= w_addr || w_data;
            isa_ff <= w_addr;
            wd_ff <= WDATA;
            rd_ff <= RD && ADDR == fir_loader_pkg::H_REG_DATA;
            rdata_ff <= rsel;
            if (BUS.rvalid) status_ff <= BUS.rdata;
            verified_q_ff <= BUS.data_word_verified;
            // Set wins over clear
            irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
            if (WR && ADDR == fir_loader_pkg::H_IRQ_MASK) irq_mask_ff <= WDATA[1:0];
        end
    end

    assign BUS.wr = wr_ff;
    assign BUS.is_addr = isa_ff;
    assign BUS.wdata = wd_ff;
    assign BUS.rd = rd_ff;
    assign RDATA = rdata_ff;
    assign IRQ = |(irq_stat_ff & irq_mask_ff);
endmodule : fir_download_host

// ===== fir_bus_chk_sva.sv
// Checker for the word bus between the host controller and the loader
`timescale 1ns/1ps
module fir_bus_chk (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic wr,
    input wire logic is_addr,
    input wire logic [15:0] wdata,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic data_word_verified
);
    logic dl_ff;
    logic [6:0] cnt_ff, n_ff;
    logic [15:0] addr_ff, sum_ff;
    wire ctl = wr && !is_addr && addr_ff == fir_loader_pkg::CTRL1_ADDR;
    // Even codes are refused, so only odd codes open a download
    wire req = ctl && !dl_ff && wdata[15] && wdata[5];
    wire word = wr && !is_addr && dl_ff;
    wire last = word && cnt_ff == n_ff;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    always_ff @(posedge CLK) begin
        if (SRST) begin
            dl_ff <= 1'b0;
            addr_ff <= 16'h0000;
        end else begin
            if (wr && is_addr) begin
                addr_ff <= wdata;
            end
            if (req) begin
                dl_ff <= 1'b1;
            end else if (last) begin
                dl_ff <= 1'b0;
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (req) begin
            cnt_ff <= 7'h00;
            n_ff <= 7'h06 * {3'h0, wdata[8:5]} + 7'h06;
            sum_ff <= 16'h0000;
        end else if (word) begin
            cnt_ff <= cnt_ff + 7'h01;
            sum_ff <= sum_ff + {8'h00, wdata[15:8]} + {8'h00, wdata[7:0]};
        end
    end
    property p_rd; rd |=> rvalid; endproperty
    a_rd: assert property (p_rd) else $error("no read answer");
    property p_rv; rvalid |-> $past(rd); endproperty
    a_rv: assert property (p_rv) else $error("answer without read");
    property p_one; !(wr && rd); endproperty
    a_one: assert property (p_one) else $error("write and read together");
    property p_clr; req |=> !data_word_verified; endproperty
    a_clr: assert property (p_clr) else $error("stale verified flag");
    property p_sum; last |=> data_word_verified == ($past(wdata) == $past(sum_ff)); endproperty
    a_sum: assert property (p_sum) else $error("checksum verdict wrong");
    property p_rose; $rose(data_word_verified) |-> $past(last); endproperty
    a_rose: assert property (p_rose) else $error("flag set off checksum");
    property p_hold; $changed(data_word_verified) |-> $past(last) || $past(req); endproperty
    a_hold: assert property (p_hold) else $error("flag moved alone");
    property p_pad; word && !cnt_ff[0] && cnt_ff < n_ff |-> wdata[15:11] == 5'h00; endproperty
    a_pad: assert property (p_pad) else $error("pad bits set");
endmodule : fir_bus_chk

// ===== testbench.sv
// Testbench joining host controller and loader, with queued expectations
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
    logic CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, IRQ, BUSY, probe = 1'b0, probe_d = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000, RDATA;
    logic [5:0] COEFF_IDX = 6'h00;
    logic [26:0] COEFF_VAL;
    logic [1:0] sel = 2'h0, sel_d = 2'h0;
    logic [31:0] expq[$];
    logic [31:0] rng = 32'he528, got;
    logic [26:0] mem [0:47];
    int fail_count = 0, n_checks = 0;
    fir_bus_if fir_bus_if_i();
    fir_coefficient_loader fir_coefficient_loader_i(.CLK(CLK), .SRST(SRST), .BUS(fir_bus_if_i),
        .COEFF_IDX(COEFF_IDX), .COEFF_VAL(COEFF_VAL), .BUSY(BUSY));
    fir_download_host fir_download_host_i(.CLK(CLK), .SRST(SRST), .BUS(fir_bus_if_i),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
    fir_bus_chk fir_bus_chk_i(.CLK(CLK), .SRST(SRST), .wr(fir_bus_if_i.wr),
        .is_addr(fir_bus_if_i.is_addr), .wdata(fir_bus_if_i.wdata), .rd(fir_bus_if_i.rd),
        .rdata(fir_bus_if_i.rdata), .rvalid(fir_bus_if_i.rvalid),
        .data_word_verified(fir_bus_if_i.data_word_verified));
    always #5 CLK = ~CLK;
    function automatic logic [15:0] bsum(input logic [15:0] w);
        return {8'h00, w[15:8]} + {8'h00, w[7:0]};
    endfunction : bsum
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wreg
    // Source 0 is a register read, 1 a stored coefficient, 2 the verified flag, 3 the irq
    task automatic expect_val(input logic [1:0] s, input logic [5:0] i, input logic [31:0] e);
        @(posedge CLK);
        sel <= s;
        COEFF_IDX <= i;
        ADDR <= i[3:0];
        RD <= (s == 2'h0);
        probe <= 1'b1;
        expq.push_back(e);
        @(posedge CLK);
        probe <= 1'b0;
        RD <= 1'b0;
    endtask : expect_val
    task automatic download(input logic [3:0] code, input logic bad);
        logic [15:0] hi, lo, sum;
        sum = 16'h0000;
        wreg(fir_loader_pkg::H_REG_ADDR, fir_loader_pkg::CTRL1_ADDR);
        wreg(fir_loader_pkg::H_REG_DATA, {1'b1, 6'h00, code, 5'h00});
        for (int k = 0; k < 48; k++) begin
            rng ^= rng << 13;
            rng ^= rng >> 17;
            rng ^= rng << 5;
            hi = {5'h00, rng[26:16]};
            lo = rng[15:0];
            mem[k] = (k < 3 * (code + 1)) ? {hi[10:0], lo} : 27'h0;
            if (k < 3 * (code + 1)) begin
                wreg(fir_loader_pkg::H_COEFF, hi);
                wreg(fir_loader_pkg::H_COEFF, lo);
                sum = sum + bsum(hi) + bsum(lo);
            end
        end
        wreg(fir_loader_pkg::H_CHECK, sum ^ {15'h0000, bad});
        repeat (60) @(posedge CLK);
    endtask : download
    task automatic verify(input logic e, input logic all);
        expect_val(2'h2, 6'h00, {31'h0, e});
        for (int k = 0; k < 48 && all; k++) begin
            expect_val(2'h1, k[5:0], {5'h00, mem[k]});
        end
    endtask : verify
    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    always @(posedge CLK) begin
        probe_d <= probe;
        sel_d <= sel;
    end
    // Compared mid-cycle so the registered answers have settled
    always @(negedge CLK) begin
        if (probe_d) begin
            got = sel_d == 2'h0 ? {16'h0000, RDATA} : sel_d == 2'h1 ? {5'h00, COEFF_VAL} :
                {31'h0, sel_d == 2'h2 ? fir_bus_if_i.data_word_verified : IRQ};
            `CHK(got, expq.pop_front())
        end
    end
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        for (int r = 0; r < 2; r++) begin
            SRST <= 1'b1;
            repeat (3) @(posedge CLK);
            SRST <= 1'b0;
            for (int k = 0; k < 48; k++) mem[k] = fir_loader_pkg::DEFAULT_COEFF[k];
            verify(1'b0, 1'b1);
            for (int c = 1; c < 16 && r == 0; c += 2) begin
                download(c[3:0], 1'b0);
                verify(1'b1, 1'b1);
            end
        end
        wreg(fir_loader_pkg::H_IRQ_STAT, 16'h0003);
        download(4'h3, 1'b0);
        expect_val(2'h0, fir_loader_pkg::H_IRQ_STAT, 32'h0000_0002);
        wreg(fir_loader_pkg::H_IRQ_STAT, 16'h0002);
        expect_val(2'h3, 6'h00, 32'h0);
        wreg(fir_loader_pkg::H_IRQ_MASK, 16'h0003);
        wreg(fir_loader_pkg::H_REG_ADDR, fir_loader_pkg::STATUS_ADDR);
        expect_val(2'h0, fir_loader_pkg::H_REG_DATA, 32'h0);
        // Status word lands in the host three edges after the read strobe
        repeat (3) @(posedge CLK);
        expect_val(2'h0, fir_loader_pkg::H_STATUS, 32'h0000_0080);
        expect_val(2'h3, 6'h00, 32'h1);
        download(4'h1, 1'b1);
        verify(1'b0, 1'b0);
        give_verdict();
    end
endmodule : testbench
